//--- logic/asram_host.sv
// Host controller that drives an asynchronous 8-bit SRAM through its pins.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Write starts when all three are active; first release ends it.
// - Host presents write data once the turn time after strobe fall has passed, well before the terminating edge.
// - Address changes only after strobe has risen, recovery zero or more.
// - Output enable held deasserted through every write.
// - Host drives data only after memory outputs have had time to float.
// - Selects stay active the full strobe time before write end.
// - Address held stable the full strobe time before write end.
// - Write data held through the strobe rising edge.
// - Address is valid no later than the selects become active.
// - Device is deselected before retention is entered.
// - After retention, wait one read cycle time before selecting again.
// - 19-bit byte address and eight data lines.
module asram_host #(
  parameter bit SLOW_GRADE = 1'b0
) (
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire asram_pkg::asram_req_t      req,
  input  wire logic                       req_valid,
  output var  logic                       req_ready,
  output var  logic [asram_pkg::DATA_W-1:0] rdata,
  output var  logic                       rdata_valid,
  output var  logic                       write_done,
  input  wire logic                       retention_req,
  output var  logic                       retention_ok,
  output var  asram_pkg::asram_pins_t     pins,
  input  wire logic [asram_pkg::DATA_W-1:0] dq_in
);
  import asram_pkg::*;

  // Grade-dependent counts, all rounded up to whole cycles.
  localparam int RD_CYC  = SLOW_GRADE ? CYC_READ_SLOW  : CYC_READ_FAST;
  localparam int WR_CYC  = SLOW_GRADE ? CYC_WSTR_SLOW  : CYC_WSTR_FAST;
  localparam int FL_CYC  = SLOW_GRADE ? CYC_FLOAT_SLOW : CYC_FLOAT_FAST;
  localparam int TU_CYC  = SLOW_GRADE ? CYC_TURN_SLOW  : CYC_TURN_FAST;
  localparam int RC_CYC  = SLOW_GRADE ? CYC_RCV_SLOW   : CYC_RCV_FAST;
  // Three stages plus the agreeing output flop: a new level needs four cycles to show.
  localparam int SYNC_LAT = 4;
  localparam int RS_CYC   = RD_CYC + SYNC_LAT;
  localparam int CNT_MAX  = (1 << CNT_W) - 1;

  // A count beyond the counter would wrap and cut an interval short, so refuse it.
  if (RS_CYC > CNT_MAX || WR_CYC > CNT_MAX || RC_CYC > CNT_MAX ||
      TU_CYC > CNT_MAX || FL_CYC > CNT_MAX) begin : g_cnt_chk
    $error("asram_host: timing count exceeds counter width");
  end

  typedef enum logic [2:0] {
    ASRAM_IDLE   = 3'b000,
    ASRAM_RD     = 3'b001,
    ASRAM_FLOAT  = 3'b010,
    ASRAM_WR     = 3'b011,
    ASRAM_WHOLD  = 3'b100,
    ASRAM_RET    = 3'b101,
    ASRAM_RECOV  = 3'b110
  } asram_state_t;

  asram_state_t       state_r, state_nxt;
  logic [CNT_W-1:0]   cnt_r, cnt_nxt;
  asram_pins_t        pins_r, pins_nxt;
  logic [DATA_W-1:0]  rdata_r, rdata_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic               wdone_r, wdone_nxt;
  logic               ready_r, ready_nxt;
  logic               ret_r, ret_nxt;
  logic [DATA_W-1:0]  dq_sync;

  // Data pins arrive without a clock relation, so they pass the synchroniser.
  asram_sync #(
    .WIDTH (DATA_W)
  ) u_dq_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      (dq_in),
    .q      (dq_sync)
  );

  // Next-state logic for the access sequencer and every pin.
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    pins_nxt   = pins_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    wdone_nxt  = 1'b0;
    ready_nxt  = 1'b0;
    ret_nxt    = ret_r;
    unique case (state_r)
      ASRAM_IDLE: begin
        ready_nxt = 1'b1;
        if (retention_req) begin
          // Already deselected here, so retention may begin at once.
          ready_nxt = 1'b0;
          ret_nxt   = 1'b1;
          state_nxt = ASRAM_RET;
        end else if (req_valid && ready_r) begin
          ready_nxt = 1'b0;
          // Address and selects change in one edge from flops: address never later.
          pins_nxt.addr                = req.addr;
          pins_nxt.select_active_low_n = 1'b0;
          pins_nxt.select_active_high  = 1'b1;
          if (req.write) begin
            // Output enable stays high so the memory never drives during writes.
            pins_nxt.output_enable_n = 1'b1;
            pins_nxt.write_strobe_n  = 1'b0;
            pins_nxt.dq_out          = req.wdata;
            pins_nxt.dq_oe           = 1'b0;
            cnt_nxt                  = CNT_W'(TU_CYC);
            state_nxt                = ASRAM_WR;
          end else begin
            pins_nxt.output_enable_n = 1'b0;
            pins_nxt.write_strobe_n  = 1'b1;
            cnt_nxt                  = CNT_W'(RS_CYC);
            state_nxt                = ASRAM_RD;
          end
        end
      end
      ASRAM_RD: begin
        // Sample only after the worst access time plus synchroniser delay.
        if (cnt_r == '0) begin
          rdata_nxt                    = dq_sync;
          rvalid_nxt                   = 1'b1;
          pins_nxt.output_enable_n     = 1'b1;
          pins_nxt.select_active_low_n = 1'b1;
          pins_nxt.select_active_high  = 1'b0;
          cnt_nxt                      = CNT_W'(FL_CYC);
          state_nxt                    = ASRAM_FLOAT;
        end
      end
      ASRAM_FLOAT: begin
        // Let the memory release the bus before the next access can start.
        if (cnt_r == '0) begin
          state_nxt = ASRAM_IDLE;
        end
      end
      ASRAM_WR: begin
        // Drive only once the memory has had its float time after strobe fell.
        if (cnt_r == '0 && !pins_r.dq_oe) begin
          pins_nxt.dq_oe = 1'b1;
          cnt_nxt        = CNT_W'(WR_CYC);
        end else if (cnt_r == '0) begin
          // Strobe rises first; selects, address and data still stand.
          pins_nxt.write_strobe_n = 1'b1;
          cnt_nxt                 = CNT_W'(CYC_HOLD);
          state_nxt               = ASRAM_WHOLD;
        end
      end
      ASRAM_WHOLD: begin
        if (cnt_r == '0) begin
          // Recovery is zero, but release two cycles after the strobe rises for margin.
          pins_nxt.dq_oe               = 1'b0;
          pins_nxt.select_active_low_n = 1'b1;
          pins_nxt.select_active_high  = 1'b0;
          wdone_nxt                    = 1'b1;
          state_nxt                    = ASRAM_IDLE;
        end
      end
      ASRAM_RET: begin
        // Selects hold inactive for the whole low-supply period.
        if (!retention_req) begin
          ret_nxt   = 1'b0;
          cnt_nxt   = CNT_W'(RC_CYC);
          state_nxt = ASRAM_RECOV;
        end
      end
      ASRAM_RECOV: begin
        if (cnt_r == '0) begin
          state_nxt = ASRAM_IDLE;
        end
      end
      default: begin
        state_nxt = ASRAM_IDLE;
      end
    endcase
  end

  // Registers; reset leaves the memory deselected with the bus released.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= ASRAM_IDLE;
      cnt_r    <= '0;
      pins_r   <= '{addr: '0, select_active_low_n: 1'b1, select_active_high: 1'b0,
                    write_strobe_n: 1'b1, output_enable_n: 1'b1, dq_out: '0, dq_oe: 1'b0};
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
      wdone_r  <= 1'b0;
      ready_r  <= 1'b0;
      ret_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      pins_r   <= pins_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      wdone_r  <= wdone_nxt;
      ready_r  <= ready_nxt;
      ret_r    <= ret_nxt;
    end
  end

  assign pins         = pins_r;
  assign rdata        = rdata_r;
  assign rdata_valid  = rvalid_r;
  assign write_done   = wdone_r;
  assign req_ready    = ready_r;
  assign retention_ok = ret_r;
endmodule
`default_nettype wire

//--- logic/asram_pkg.sv
// Package for the asynchronous SRAM host controller: widths, timing and carrier types.
`default_nettype none
package asram_pkg;
  // Clock period in picoseconds (100 MHz).
  localparam int CLK_PERIOD_PS = 10000;
  // Pin widths.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // Timing figures in ns, fast grade then slow grade.
  localparam int READ_CYCLE_TIME_NS_FAST           = 70;
  localparam int READ_CYCLE_TIME_NS_SLOW           = 85;
  localparam int ADDRESS_ACCESS_TIME_NS_FAST       = 70;
  localparam int ADDRESS_ACCESS_TIME_NS_SLOW       = 85;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS_FAST = 40;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS_SLOW = 85;
  localparam int DISABLE_TO_FLOAT_TIME_NS_FAST     = 25;
  localparam int DISABLE_TO_FLOAT_TIME_NS_SLOW     = 30;
  localparam int DESELECT_TO_FLOAT_TIME_NS         = 30;
  localparam int SELECT_TO_WRITE_END_NS_FAST       = 60;
  localparam int SELECT_TO_WRITE_END_NS_SLOW       = 70;
  localparam int ADDRESS_TO_WRITE_END_NS_FAST      = 60;
  localparam int ADDRESS_TO_WRITE_END_NS_SLOW      = 70;
  localparam int DATA_SETUP_TIME_NS_FAST           = 35;
  localparam int DATA_SETUP_TIME_NS_SLOW           = 40;
  localparam int STROBE_TO_FLOAT_TIME_NS_FAST      = 20;
  localparam int STROBE_TO_FLOAT_TIME_NS_SLOW      = 25;
  localparam int WRITE_RECOVERY_TIME_NS            = 0;
  localparam int DATA_HOLD_TIME_NS                 = 0;
  localparam int DESELECT_TO_RETENTION_TIME_NS     = 0;
  // Cycle counts; a least time rounds up and never falls below one cycle.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int CYC_READ_FAST  = ns_to_cyc(ADDRESS_ACCESS_TIME_NS_FAST);
  localparam int CYC_READ_SLOW  = ns_to_cyc(ADDRESS_ACCESS_TIME_NS_SLOW);
  localparam int CYC_FLOAT_FAST = ns_to_cyc(DESELECT_TO_FLOAT_TIME_NS);
  localparam int CYC_FLOAT_SLOW = ns_to_cyc(DESELECT_TO_FLOAT_TIME_NS);
  localparam int CYC_WSTR_FAST  = ns_to_cyc(SELECT_TO_WRITE_END_NS_FAST);
  localparam int CYC_WSTR_SLOW  = ns_to_cyc(SELECT_TO_WRITE_END_NS_SLOW);
  localparam int CYC_TURN_FAST  = ns_to_cyc(DISABLE_TO_FLOAT_TIME_NS_FAST);
  localparam int CYC_TURN_SLOW  = ns_to_cyc(DISABLE_TO_FLOAT_TIME_NS_SLOW);
  localparam int CYC_RCV_FAST   = ns_to_cyc(READ_CYCLE_TIME_NS_FAST);
  localparam int CYC_RCV_SLOW   = ns_to_cyc(READ_CYCLE_TIME_NS_SLOW);
  localparam int CYC_HOLD       = ns_to_cyc(DATA_HOLD_TIME_NS);
  localparam int CNT_W = 4;
  // Pins toward the memory, all driven from flip-flops.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              select_active_low_n;
    logic              select_active_high;
    logic              write_strobe_n;
    logic              output_enable_n;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } asram_pins_t;
  // User request.
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asram_req_t;
endpackage
`default_nettype wire

//--- logic/asram_sync.sv
// Three-stage input synchroniser; the output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module asram_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
  logic [WIDTH-1:0] q_nxt;

  // Per bit, accept a new level only when the later stages agree, filtering a late settle.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
  end

  // The first stage feeds only the second.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

//--- verification/asram_host_props.sv
// Checker for the pin sequencing of the SRAM host controller.
`timescale 1ns/1ps
`default_nettype none
module asram_host_props #(
  parameter bit SLOW_GRADE = 1'b0
) (
  input wire logic                   clock,
  input wire logic                   arst_n,
  input wire logic                   rdata_valid,
  input wire logic                   retention_ok,
  input wire asram_pkg::asram_pins_t pins
);
  import asram_pkg::*;
  // From the sampled enable fall: access count, four synchroniser cycles, one register.
  localparam int RD_LAT = (SLOW_GRADE ? CYC_READ_SLOW : CYC_READ_FAST) + 5;
  logic sel;
  // Both selects active means the memory is enabled.
  assign sel = !pins.select_active_low_n && pins.select_active_high;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_strobe_sel; !pins.write_strobe_n |-> sel && pins.output_enable_n; endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe low without select");
  property p_turn; $fell(pins.write_strobe_n) |-> !pins.dq_oe [*3]; endproperty
  a_turn: assert property (p_turn) else $error("host drove data too early");
  property p_strobe_len; $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*6]; endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("write strobe too short");
  property p_addr_hold; sel && $past(sel) |-> $stable(pins.addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while selected");
  property p_data_hold; $rose(pins.write_strobe_n) |-> pins.dq_oe && $stable(pins.dq_out); endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held");
  property p_no_clash; !pins.output_enable_n |-> !pins.dq_oe; endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives during read");
  property p_ret; retention_ok |-> !sel; endproperty
  a_ret: assert property (p_ret) else $error("selected during retention");
  property p_ret_rcv; $fell(retention_ok) |-> !sel [*7]; endproperty
  a_ret_rcv: assert property (p_ret_rcv) else $error("selected too soon after retention");
  property p_read_lat; $fell(pins.output_enable_n) |-> ##RD_LAT rdata_valid; endproperty
  a_read_lat: assert property (p_read_lat) else $error("read sample time wrong");
  c_read: cover property ($fell(pins.output_enable_n));
  c_write: cover property ($rose(pins.write_strobe_n));
  c_ret: cover property ($fell(retention_ok));
endmodule
bind asram_host asram_host_props #(.SLOW_GRADE(SLOW_GRADE)) u_props (
  .clock(clock), .arst_n(arst_n), .rdata_valid(rdata_valid),
  .retention_ok(retention_ok), .pins(pins));
`default_nettype wire

//--- verification/asram_mem_model.sv
// Behavioural model of the asynchronous SRAM as seen from the host pins.
`timescale 1ns/1ps
`default_nettype none
module asram_mem_model #(
  parameter int ACC_NS   = 70,
  parameter int FLOAT_NS = 20
) (
  input  wire asram_pkg::asram_pins_t         pins,
  output var  logic [asram_pkg::DATA_W-1:0]   dq_in
);
  import asram_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] bus = 8'h5a;
  logic              sel;
  logic              wr;
  logic              rd;
  // The part works only with both selects active; otherwise its pins float.
  assign sel = !pins.select_active_low_n && pins.select_active_high;
  assign wr  = sel && !pins.write_strobe_n;
  assign rd  = sel && pins.write_strobe_n && !pins.output_enable_n;
  // Data shows only after the full access time, so early sampling reads junk.
  // A floating bus shows the inverse of its last value, never a kind constant.
  always @(rd or pins.addr) begin
    if (rd) bus <= #(ACC_NS) (mem.exists(pins.addr) ? mem[pins.addr] : ~bus);
    else bus <= #(FLOAT_NS) ~bus;
  end
  // The write lands when the overlap of selects and strobe ends.
  always @(negedge wr) begin
    if (pins.dq_oe === 1'b1) mem[pins.addr] = pins.dq_out;
  end
  // The host's drive wins on the wire while its enable is high.
  assign dq_in = pins.dq_oe ? pins.dq_out : bus;
endmodule
`default_nettype wire

//--- verification/async_sram_access_timing_bench.sv
// Self-checking bench for the SRAM host controller against a memory model.
`timescale 1ns/1ps
`default_nettype none
module async_sram_access_timing_bench;
  import asram_pkg::*;
  typedef struct packed { logic rd; logic [DATA_W-1:0] data; } asram_exp_t;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  asram_req_t        req = '0;
  logic              req_valid = 1'b0;
  logic              retention_req = 1'b0;
  logic              req_ready;
  logic              rdata_valid;
  logic              write_done;
  logic              retention_ok;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] dq_in;
  asram_pins_t       pins;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  asram_exp_t        exp_q [$];
  asram_exp_t        mon_e;
  int                err_total = 0;
  int                compares = 0;
  // Free-running 100 MHz clock.
  always #5 clock = ~clock;
  asram_host #(.SLOW_GRADE(1'b0)) dut (
    .clock(clock), .arst_n(arst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .write_done(write_done), .retention_req(retention_req),
    .retention_ok(retention_ok), .pins(pins), .dq_in(dq_in));
  asram_mem_model #(.ACC_NS(70), .FLOAT_NS(20)) u_mem (.pins(pins), .dq_in(dq_in));
  task automatic fail(input string msg);
    err_total++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask
  task automatic chk_read(input logic [DATA_W-1:0] exp);
    compares++;
    if (rdata !== exp) fail("read byte differs");
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) fail(what);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Outputs are read mid-cycle where settled; each completion retires the oldest note.
  always @(negedge clock) begin
    if (rdata_valid === 1'b1 || write_done === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected completion");
      else begin
        mon_e = exp_q.pop_front();
        if (mon_e.rd) begin
          chk_flag(rdata_valid, 1'b1, "read completion missing");
          chk_read(mon_e.data);
        end else chk_flag(write_done, 1'b1, "write completion missing");
      end
    end
  end
  // One request held until the edge that takes it; the first edge avoids a double drive.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    bit tk;
    tk = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d};
    for (n = 0; n < 40 && !tk; n++) begin
      @(posedge clock);
      tk = (req_ready === 1'b1);
    end
    req_valid <= 1'b0;
    if (!tk) begin
      fail("request not taken");
      complete_run();
    end
    if (wr) ref_mem[a] = d;
    exp_q.push_back('{rd: !wr, data: wr ? 8'h00 : ref_mem[a]});
  endtask
  task automatic drain(input string name);
    int n;
    for (n = 0; n < 100 && exp_q.size() != 0; n++) @(posedge clock);
    if (exp_q.size() != 0) begin
      fail("completion missing");
      complete_run();
    end
    $display("test %s done", name);
  endtask
  // Main sequence.
  initial begin
    logic [ADDR_W-1:0] a;
    int i;
    void'($urandom(84));
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    // Random bytes at both address corners and between, written then read back.
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? '0 : (i == 1) ? '1 : ADDR_W'($urandom);
      access(1'b1, a, DATA_W'($urandom));
      access(1'b0, a, 8'h00);
    end
    drain("corners");
    // Overwrite one place, then back-to-back reads of two places.
    access(1'b1, 19'h1_2345, 8'ha5);
    access(1'b1, 19'h1_2345, 8'h3c);
    access(1'b0, 19'h1_2345, 8'h00);
    access(1'b0, a, 8'h00);
    drain("overwrite");
    // Retention: the part is deselected and no access starts until released.
    // The grant waits for the bus float after the last read, so allow a few cycles.
    retention_req <= 1'b1;
    for (i = 0; i < 10 && retention_ok !== 1'b1; i++) @(negedge clock);
    chk_flag(retention_ok, 1'b1, "retention not granted");
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      #1 chk_flag(req_ready, 1'b0, "ready during retention");
    end
    @(posedge clock);
    retention_req <= 1'b0;
    access(1'b0, 19'h1_2345, 8'h00);
    drain("retention");
    complete_run();
  end
endmodule
`default_nettype wire
